// ### common/dem_pkg.sv
// Shared constants and types for the decimal edit-and-mark datapath
`default_nettype none
package dem_pkg;
  // Address, field-length and flag word widths
  localparam int ADDR_W = 48;
  localparam int LEN_W  = 16;
  localparam int DFB_W  = 64;
  // Data flag bit positions
  localparam int DFB_FAULT = 38;
  localparam int DFB_ZERO  = 53;
  localparam int DFB_NEG   = 54;
  localparam int DFB_POS   = 55;
  // Zone nibbles for a stored digit
  localparam logic [3:0] ZONE_ASCII  = 4'h3;
  localparam logic [3:0] ZONE_EBCDIC = 4'hF;
  // Blank codes used as default fill
  localparam logic [7:0] BLANK_ASCII  = 8'h20;
  localparam logic [7:0] BLANK_EBCDIC = 8'h40;
  // Special pattern characters: sel, body, code
  localparam logic [1:0] SEL_ASCII  = 2'h3;
  localparam logic [1:0] SEL_EBCDIC = 2'h0;
  localparam logic [3:0] SEL_BODY   = 4'h8;
  localparam logic [1:0] CODE_DS    = 2'h0;
  localparam logic [1:0] CODE_SS    = 2'h1;
  localparam logic [1:0] CODE_FS    = 2'h2;
  localparam logic [1:0] CODE_ID    = 2'h3;
  // Sign nibble codes
  localparam logic [3:0] SIGN_MIN = 4'hA;
  localparam logic [3:0] MINUS_A  = 4'hB;
  localparam logic [3:0] MINUS_B  = 4'hD;
  // Upper mark bits at completion
  localparam logic [15:0] MARK_HI_CLR = 16'h0000;
  // Reset value of an index
  localparam logic [LEN_W-1:0] IDX_RST = 16'h0000;

  // Pattern character classes
  typedef enum logic [2:0] {P_MSG, P_DS, P_SS, P_FS, P_ID} dem_pat_t;

  // One byte storage access
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } dem_mem_cmd_t;

  // Operand descriptors of one operation
  typedef struct packed {
    logic [ADDR_W-1:0] a_base;
    logic [LEN_W-1:0]  a_len;
    logic [ADDR_W-1:0] b_base;
    logic [LEN_W-1:0]  b_len;
    logic [ADDR_W-1:0] c_base;
    logic [LEN_W-1:0]  c_len;
    logic              ascii;
  } dem_op_t;
endpackage
`default_nettype wire

// ### rtl/dem_edit_unit.sv
// Decimal edit-and-mark datapath: pattern, source and result sequencing
// What this block does
// - Sign in upper source nibble sets fault
// - Digit pattern after sign in field faults
// - After fault only the fault flag counts
// - Stop when result full or pattern ends
// - Exactly one zero/negative/positive status flag when no fault, none on a fault
// - Mark holds address before the nonzero digit that starts significance
// - Ordinary first pattern character becomes fill
// - Digit select: fill zeros until significant
// - Significance start sets the flip-flop
// - Plus sign clears flip-flop, writes nothing
// - Minus sign keeps flip-flop, messages copied
// - After plus, messages and zeros give fill
// - Special first character makes blank fill
// - Field separator clears flip-flop, stores fill
// - Later negative field updates mark address
// - Full result stops; status from examined digits
// - Mark undefined after misplaced sign
// - Zone nibble chosen by character set bit
// - Plus codes clear, minus codes keep flip-flop
`default_nettype none
module dem_edit_unit
  import dem_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic              start_i,
  input  wire dem_pkg::dem_op_t  op_i,
  input  wire logic [63:0]       mark_init_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic [63:0]            data_flag_bits_o,
  output logic [63:0]            mark_o,
  output logic                   mem_req_o,
  output dem_pkg::dem_mem_cmd_t  mem_cmd_o,
  input  wire logic              mem_ack_i,
  input  wire logic [7:0]        mem_rdata_i
);
  import dem_pkg::*;

  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_PAT_RD, S_PAT_WT, S_EXEC, S_SRC_RD,
    S_SRC_WT, S_WR, S_WR_WT, S_END
  } dem_state_t;

  dem_state_t        state;      // Current step
  dem_op_t           op;         // Latched operands
  logic [LEN_W-1:0]  a_idx;      // Next source byte
  logic [LEN_W-1:0]  b_idx;      // Next pattern byte
  logic [LEN_W-1:0]  c_idx;      // Next result byte
  logic [7:0]        pat;        // Pattern character in hand
  logic [7:0]        src;        // Source byte in hand
  logic              have_src;   // Source byte has a digit left
  logic              right;      // Next digit is the low nibble
  logic              first;      // First pattern character pending
  logic              tff;        // Significance flip-flop
  logic              sign_seen;  // Sign examined in this field
  logic              field_nz;   // Nonzero digit in this field
  logic              fault_q;    // Decimal data fault seen
  logic [7:0]        fill;       // Fill character
  logic [7:0]        wchar_q;    // Byte to be stored
  logic [ADDR_W-1:0] mark;       // Mark address
  // Storage port wires
  logic              p_valid;
  dem_mem_cmd_t      p_cmd;
  logic              p_done;
  logic [7:0]        p_rdata;
  // Execution decode
  dem_pat_t          cls;
  logic [3:0]        digit;
  logic [7:0]        zoned;
  logic [7:0]        blank;
  logic              need_src;
  logic              low_sign;
  logic              step;
  logic              next_t;
  logic              do_wr;
  logic [7:0]        next_wchar;
  logic              set_mark;
  logic              dig_nz;
  logic              two_fields;

  // Nibble is a sign code
  function automatic logic is_sign(input logic [3:0] n);
    return n >= SIGN_MIN;
  endfunction

  // Nibble is a plus sign code
  function automatic logic is_plus(input logic [3:0] n);
    return is_sign(n) && n != MINUS_A && n != MINUS_B;
  endfunction

  // Pattern character class for the character set
  function automatic dem_pat_t classify(input logic [7:0] c,
                                        input logic       asc);
    dem_pat_t r;
    r = P_MSG;
    if (c[7:6] == (asc ? SEL_ASCII : SEL_EBCDIC) && c[5:2] == SEL_BODY)
    begin
      case (c[1:0])
        CODE_DS: r = P_DS;
        CODE_SS: r = P_SS;
        CODE_FS: r = P_FS;
        default: r = P_ID;
      endcase
    end
    return r;
  endfunction

  // Storage access sequencer
  dem_mem_port u_port (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .cmd_valid_i (p_valid),
    .cmd_i       (p_cmd),
    .cmd_done_o  (p_done),
    .rdata_o     (p_rdata),
    .mem_req_o   (mem_req_o),
    .mem_cmd_o   (mem_cmd_o),
    .mem_ack_i   (mem_ack_i),
    .mem_rdata_i (mem_rdata_i)
  );

  // Operand decode for the character in hand
  assign cls      = classify(pat, op.ascii);
  assign digit    = right ? src[3:0] : src[7:4];
  assign zoned    = {op.ascii ? ZONE_ASCII : ZONE_EBCDIC, digit};
  assign blank    = op.ascii ? BLANK_ASCII : BLANK_EBCDIC;
  assign need_src = (cls == P_DS) || (cls == P_ID);
  assign low_sign = !right && is_sign(src[3:0]);
  assign step     = !first && !(need_src && !have_src);
  assign two_fields = need_src && sign_seen;
  assign busy_o   = state != S_IDLE;

  // Edit decision for one pattern character
  always_comb
  begin
    next_t     = tff;
    do_wr      = 1'b0;
    next_wchar = fill;
    set_mark   = 1'b0;
    dig_nz     = 1'b0;
    unique case (cls)
      P_DS:
      begin
        do_wr  = 1'b1;
        dig_nz = digit != 4'h0;
        if (tff)
          next_wchar = zoned;
        else if (dig_nz)
        begin
          next_t     = 1'b1;
          set_mark   = 1'b1;
          next_wchar = zoned;
        end
      end
      // Skips a digit, no sample, no store
      P_ID: ;
      P_SS: next_t = 1'b1;
      P_FS:
      begin
        next_t = 1'b0;
        do_wr  = 1'b1;
      end
      // Message: copied only while significant
      P_MSG:
      begin
        do_wr      = 1'b1;
        next_wchar = tff ? pat : fill;
      end
    endcase
    // Trailing sign acts after its digit
    if (need_src && low_sign && is_plus(src[3:0]))
      next_t = 1'b0;
  end

  // Storage command for the current step
  always_comb
  begin
    p_valid = 1'b0;
    p_cmd   = '0;
    unique case (state)
      S_PAT_RD:
      begin
        p_valid    = b_idx != op.b_len;
        p_cmd.addr = op.b_base + ADDR_W'(b_idx);
      end
      S_SRC_RD:
      begin
        p_valid    = 1'b1;
        p_cmd.addr = op.a_base + ADDR_W'(a_idx);
      end
      S_WR:
      begin
        p_valid     = 1'b1;
        p_cmd.we    = 1'b1;
        p_cmd.addr  = op.c_base + ADDR_W'(c_idx);
        p_cmd.wdata = wchar_q;
      end
      default: ;
    endcase
  end

  // Step sequencer
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      state <= S_IDLE;
    else
    begin
      unique case (state)
        S_IDLE:
          if (start_i)
            state <= (op_i.c_len == IDX_RST) ? S_END : S_PAT_RD;
        S_PAT_RD:
          state <= (b_idx == op.b_len) ? S_END : S_PAT_WT;
        S_PAT_WT: if (p_done) state <= S_EXEC;
        S_EXEC:
          if (first)
            state <= (cls == P_MSG) ? S_PAT_RD : S_EXEC;
          else if (!step)
            state <= S_SRC_RD;
          else
            state <= do_wr ? S_WR : S_PAT_RD;
        S_SRC_RD: state <= S_SRC_WT;
        S_SRC_WT: if (p_done) state <= S_EXEC;
        S_WR:     state <= S_WR_WT;
        S_WR_WT:
          if (p_done)
            state <= (c_idx + 16'h0001 == op.c_len) ? S_END
                                                    : S_PAT_RD;
        S_END:    state <= S_IDLE;
      endcase
    end
  end

  // Operand latch and field indices
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      op    <= '0;
      a_idx <= IDX_RST;
      b_idx <= IDX_RST;
      c_idx <= IDX_RST;
      pat   <= 8'h00;
    end
    else if (state == S_IDLE && start_i)
    begin
      op    <= op_i;
      a_idx <= IDX_RST;
      b_idx <= IDX_RST;
      c_idx <= IDX_RST;
    end
    else
    begin
      if (state == S_PAT_WT && p_done)
        pat <= p_rdata;
      if (state == S_SRC_WT && p_done)
        a_idx <= a_idx + 16'h0001;
      if (state == S_EXEC && (step || (first && cls == P_MSG)))
        b_idx <= b_idx + 16'h0001;
      if (state == S_WR_WT && p_done)
        c_idx <= c_idx + 16'h0001;
    end
  end

  // Source byte and nibble tracking
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || (state == S_IDLE && start_i))
    begin
      src      <= 8'h00;
      have_src <= 1'b0;
      right    <= 1'b0;
    end
    else if (state == S_SRC_WT && p_done)
    begin
      src      <= p_rdata;
      have_src <= 1'b1;
      right    <= 1'b0;
    end
    else if (state == S_EXEC && step && need_src)
    begin
      // Sign in low nibble ends the byte
      if (right || low_sign)
        have_src <= 1'b0;
      else
        right <= 1'b1;
    end
  end

  // Significance, fill, field status and fault
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || (state == S_IDLE && start_i))
    begin
      first     <= 1'b1;
      tff       <= 1'b0;
      sign_seen <= 1'b0;
      field_nz  <= 1'b0;
      fill      <= 8'h00;
      wchar_q   <= 8'h00;
      if (reset_i)
        fault_q <= 1'b0;
      else
        fault_q <= 1'b0;
    end
    else
    begin
      // Sign code in the upper nibble
      if (state == S_SRC_WT && p_done && is_sign(p_rdata[7:4]))
        fault_q <= 1'b1;
      if (state == S_EXEC && first)
      begin
        first <= 1'b0;
        fill  <= (cls == P_MSG) ? pat : blank;
      end
      else if (state == S_EXEC && step)
      begin
        tff     <= next_t;
        wchar_q <= next_wchar;
        if (two_fields)
          fault_q <= 1'b1;
        if (dig_nz)
          field_nz <= 1'b1;
        if (need_src && low_sign)
          sign_seen <= 1'b1;
        if (cls == P_FS)
        begin
          sign_seen <= 1'b0;
          field_nz  <= 1'b0;
        end
      end
    end
  end

  // Mark address, reloaded per field at the nonzero digit that starts significance
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      mark <= '0;
    else if (state == S_IDLE && start_i)
      mark <= mark_init_i[ADDR_W-1:0];
    else if (state == S_EXEC && step && set_mark)
      mark <= op.c_base + ADDR_W'(c_idx) - ADDR_W'(1);
  end

  // Completion outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      done_o           <= 1'b0;
      data_flag_bits_o <= '0;
      mark_o           <= '0;
    end
    else
    begin
      done_o <= state == S_END;
      if (state == S_END)
      begin
        data_flag_bits_o            <= '0;
        data_flag_bits_o[DFB_FAULT] <= fault_q;
        if (!fault_q)
        begin
          data_flag_bits_o[DFB_ZERO] <= !field_nz;
          data_flag_bits_o[DFB_NEG]  <= field_nz && tff;
          data_flag_bits_o[DFB_POS]  <= field_nz && !tff;
        end
        mark_o <= {MARK_HI_CLR, mark};
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  one_status_a: assert property (done_o && !data_flag_bits_o[DFB_FAULT]
    |-> $onehot(data_flag_bits_o[DFB_POS:DFB_ZERO]))
    else $error("status flags not one-hot");
  upper_fault_a: assert property (state == S_SRC_WT && p_done
    && is_sign(p_rdata[7:4]) |-> ##3 done_o || fault_q)
    else $error("upper nibble sign not faulted");
  second_field_a: assert property (state == S_EXEC && step
    && two_fields |=> fault_q)
    else $error("second numeric field not faulted");
  fault_flag_a: assert property (state == S_END
    |=> data_flag_bits_o[DFB_FAULT] == $past(fault_q))
    else $error("fault flag wrong at done");
  pat_end_a: assert property (state == S_PAT_RD && b_idx == op.b_len
    |=> state == S_END ##1 done_o)
    else $error("no stop at pattern end");
  result_full_a: assert property (state == S_WR_WT && p_done
    && c_idx + 16'h0001 == op.c_len |=> state == S_END)
    else $error("no stop on full result");
  mark_high_a: assert property (done_o
    |-> mark_o[63:48] == MARK_HI_CLR && !busy_o)
    else $error("mark upper bits not cleared");
  first_fill_a: assert property (state == S_EXEC && first
    && cls == P_MSG |=> fill == $past(pat) && state == S_PAT_RD)
    else $error("fill not latched from pattern");
  blank_fill_a: assert property (state == S_EXEC && first
    && cls != P_MSG |=> fill == blank && state == S_EXEC)
    else $error("blank fill not used");
  sig_start_a: assert property (state == S_EXEC && step
    && cls == P_SS |=> tff && state == S_PAT_RD)
    else $error("significance start did not set");
  plus_clear_a: assert property (state == S_EXEC && step && need_src
    && low_sign && is_plus(src[3:0]) |=> !tff)
    else $error("plus sign left flip-flop set");
  sep_fill_a: assert property (state == S_EXEC && step && cls == P_FS
    |=> !tff && wchar_q == fill && state == S_WR)
    else $error("separator did not store fill");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
endmodule // dem_edit_unit
`default_nettype wire

// ### rtl/dem_mem_port.sv
// Single outstanding byte access toward main storage
`default_nettype none
module dem_mem_port
  import dem_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  cmd_valid_i,
  input  wire dem_pkg::dem_mem_cmd_t cmd_i,
  output logic                       cmd_done_o,
  output logic [7:0]                 rdata_o,
  output logic                       mem_req_o,
  output dem_pkg::dem_mem_cmd_t      mem_cmd_o,
  input  wire logic                  mem_ack_i,
  input  wire logic [7:0]            mem_rdata_i
);
  logic pend;  // Access waiting for acknowledge

  // Take a command when idle, hold it until acknowledged
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      pend       <= 1'b0;
      mem_cmd_o  <= '0;
      cmd_done_o <= 1'b0;
      rdata_o    <= 8'h00;
    end
    else
    begin
      cmd_done_o <= pend && mem_ack_i;
      if (!pend && cmd_valid_i)
      begin
        pend      <= 1'b1;
        mem_cmd_o <= cmd_i;
      end
      else if (pend && mem_ack_i)
      begin
        pend    <= 1'b0;
        rdata_o <= mem_rdata_i;  // Read byte, don't care on a write
      end
    end
  end

  assign mem_req_o = pend;
endmodule // dem_mem_port
`default_nettype wire

// ### sim/dem_mem_model.sv
// Byte-wide main storage model serving the edit unit's requests
`default_nettype none
module dem_mem_model
  import dem_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  req_i,
  input  wire dem_pkg::dem_mem_cmd_t cmd_i,
  input  wire logic [3:0]            lat_i,
  output logic                       ack_o,
  output logic [7:0]                 rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [4096]; // Storage bytes, low 12 address bits
  logic [3:0] wait_q;     // Cycles already waited on this request

  // Quiet start before the first request
  initial
  begin
    ack_o   = 1'b0;
    rdata_o = 8'h00;
    wait_q  = 4'h0;
  end

  // Answer after lat_i cycles; idle data line toggles every cycle
  always @(posedge sys_clk_i)
  begin
    ack_o   <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o)
    begin
      if (wait_q >= lat_i)
      begin
        ack_o  <= 1'b1;
        wait_q <= 4'h0;
        if (cmd_i.we)
          mem[cmd_i.addr[11:0]] <= cmd_i.wdata;
        else
          rdata_o <= mem[cmd_i.addr[11:0]];
      end
      else
        wait_q <= wait_q + 4'h1;
    end
  end
endmodule // dem_mem_model
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the decimal edit-and-mark datapath
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dem_pkg::*;

  localparam logic [63:0] G0 = 64'hFFFF_0000_0001_0000; // Prior mark

  logic         sys_clk_i;        // 40 MHz clock
  logic         reset_i;          // Synchronous reset
  logic         start_i;          // Start pulse
  dem_op_t      op_i;             // Operand descriptors
  logic [63:0]  mark_init_i;      // Mark before the operation
  logic         busy_o;           // Unit running
  logic         done_o;           // Termination pulse
  logic [63:0]  data_flag_bits_o; // Flag word
  logic [63:0]  mark_o;           // Mark result
  logic         mem_req_o;        // Storage request
  dem_mem_cmd_t mem_cmd_o;        // Storage command
  logic         mem_ack_i;        // Storage acknowledge
  logic [7:0]   mem_rdata_i;      // Storage read byte
  logic [3:0]   lat;              // Storage answer delay
  int           miscompares;      // Mismatches seen
  int           samples_checked;  // Comparisons made
  int           cyc;              // Cycles to done

  dem_edit_unit dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .start_i(start_i),
    .op_i(op_i), .mark_init_i(mark_init_i), .busy_o(busy_o),
    .done_o(done_o), .data_flag_bits_o(data_flag_bits_o),
    .mark_o(mark_o), .mem_req_o(mem_req_o), .mem_cmd_o(mem_cmd_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));

  dem_mem_model u_mem (
    .sys_clk_i(sys_clk_i), .req_i(mem_req_o), .cmd_i(mem_cmd_o),
    .lat_i(lat), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  // Free-running clock, 25 ns period
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // Compare one value and count it
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts, verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Load fields, start one operation and wait for its end
  task automatic run(string pat, logic [39:0] src, int ns, int cl,
                     bit asc);
    logic [7:0] b;
    for (int i = 0; i < 32; i++)
      u_mem.mem[12'h400 + i] = 8'hEE;
    for (int i = 0; i < pat.len(); i++)
    begin
      b = pat[i];
      case (pat[i])
        "D": b = {asc ? SEL_ASCII : SEL_EBCDIC, SEL_BODY, CODE_DS};
        "S": b = {asc ? SEL_ASCII : SEL_EBCDIC, SEL_BODY, CODE_SS};
        "F": b = {asc ? SEL_ASCII : SEL_EBCDIC, SEL_BODY, CODE_FS};
        "I": b = {asc ? SEL_ASCII : SEL_EBCDIC, SEL_BODY, CODE_ID};
        default: b = pat[i];
      endcase
      u_mem.mem[12'h200 + i] = b;
    end
    for (int i = 0; i < ns; i++)
      u_mem.mem[12'h100 + i] = src[8*(ns-1-i) +: 8];
    op_i = '{a_base: 48'h100, a_len: 16'(ns), b_base: 48'h200,
             b_len: 16'(pat.len()), c_base: 48'h400, c_len: 16'(cl),
             ascii: asc};
    @(negedge sys_clk_i);
    start_i = 1'b1;
    for (cyc = 0; cyc < 4000; cyc++)
    begin
      @(negedge sys_clk_i);
      start_i = 1'b0;
      // Unit leaves idle at the edge that takes the start
      if (cyc == 0)
        check("busy", 64'(busy_o), 64'h1);
      if (done_o === 1'b1)
        break;
    end
    if (cyc == 4000)
    begin
      miscompares++;
      $display("wrong value done expected 1 seen 0");
      final_report();
    end
    @(negedge sys_clk_i);
    check("done width", 64'(done_o), 64'h0);
    check("idle after", 64'(busy_o), 64'h0);
  endtask

  // Compare result field; digits get the mode's zone
  task automatic expect_res(string r, bit asc);
    logic [7:0] e;
    for (int i = 0; i < r.len(); i++)
    begin
      e = r[i];
      if (e inside {[8'h30:8'h39]})
        e[7:4] = asc ? 4'h3 : 4'hF;
      check("result byte", 64'(u_mem.mem[12'h400 + i]), 64'(e));
    end
    check("past end", 64'(u_mem.mem[12'h400 + r.len()]), 64'hEE);
  endtask

  // One plus-signed field, fill latched from the pattern
  task automatic t_single_plus();
    lat = 4'h0;
    run("*DD$DDDS.DDBCR", 40'h003632_9C, 4, 20, 1'b1);
    expect_res("***363.29***", 1'b1);
    check("flags", data_flag_bits_o, 64'h1 << 55);
    check("mark", mark_o, 64'h402);
    $display("test single_plus finished");
  endtask

  // Minus sign keeps significance, messages copied
  task automatic t_single_minus();
    lat = 4'h2;
    run("*DD$DDDS.DDBCR", 40'h013632_9D, 4, 20, 1'b0);
    expect_res("*1$363.29BCR", 1'b0);
    check("flags", data_flag_bits_o, 64'h1 << 54);
    check("mark", mark_o, 64'h400);
    $display("test single_minus finished");
  endtask

  // Leading start character and trailing separator
  task automatic t_blank_fill();
    lat = 4'h1;
    run("SDDDF", 40'h012C, 2, 20, 1'b1);
    expect_res("012 ", 1'b1);
    check("flags", data_flag_bits_o, 64'h1 << 53);
    check("mark", mark_o, 64'h10000);
    $display("test blank_fill finished");
  endtask

  // Two fields, second negative; then result field cut short
  task automatic t_multi_field();
    lat = 4'h3;
    run("*DDDBFBDDDDD", 40'h123C00456D, 5, 20, 1'b1);
    expect_res("123*****456", 1'b1);
    check("flags", data_flag_bits_o, 64'h1 << 54);
    check("mark", mark_o, 64'h407);
    run("*DDDBFBDDDDD", 40'h123C00456D, 5, 8, 1'b1);
    expect_res("123*****", 1'b1);
    check("flags", data_flag_bits_o, 64'h1 << 53);
    check("mark", mark_o, 64'h3FF);
    $display("test multi_field finished");
  endtask

  // Sign in upper nibble, and a second number in one field
  task automatic t_faults();
    lat = 4'h0;
    run("*DD", 40'hC1, 1, 20, 1'b1);
    check("fault flags", data_flag_bits_o, 64'h1 << 38);
    run("*DDD", 40'h1C2C, 2, 20, 1'b1);
    check("fault flags", data_flag_bits_o, 64'h1 << 38);
    $display("test faults finished");
  endtask

  // Every sign code after a skipped digit
  task automatic t_sign_codes();
    logic [63:0] ef;
    lat = 4'h1;
    for (int s = 10; s < 16; s++)
    begin
      ef = (s == 11 || s == 13) ? 64'h1 << 54 : 64'h1 << 55;
      run("*IDD", {24'h0, 8'h51, 4'h2, 4'(s)}, 2, 20, 1'b0);
      expect_res("12", 1'b0);
      check("sign flags", data_flag_bits_o, ef);
      check("mark", mark_o, 64'h3FF);
    end
    $display("test sign_codes finished");
  endtask

  // Empty result field ends at once
  task automatic t_empty_result();
    lat = 4'h0;
    run("*D", 40'h1C, 1, 0, 1'b1);
    // Start edge goes to the end step, done follows one edge later
    check("done delay", 64'(cyc), 64'h1);
    check("untouched", 64'(u_mem.mem[12'h400]), 64'hEE);
    check("flags", data_flag_bits_o, 64'h1 << 53);
    check("mark", mark_o, 64'h10000);
    $display("test empty_result finished");
  endtask

  // Reset, scenarios, verdict
  initial
  begin
    miscompares     = 0;
    samples_checked = 0;
    reset_i         = 1'b1;
    start_i         = 1'b0;
    op_i            = '0;
    mark_init_i     = G0;
    lat             = 4'h0;
    repeat (16) @(negedge sys_clk_i);
    reset_i = 1'b0;
    check("idle", 64'({busy_o, done_o, mem_req_o}), 64'h0);
    check("idle flags", data_flag_bits_o | mark_o, 64'h0);
    t_single_plus();
    t_single_minus();
    t_blank_fill();
    t_multi_field();
    t_faults();
    t_sign_codes();
    t_empty_result();
    final_report();
  end
endmodule // tb
`default_nettype wire
